// File: acps_regs.svh
`ifndef ACPS_REGS_SVH
`define ACPS_REGS_SVH

// clock rate in MHz
`define ACPS_CLK_MHZ 100
// external sync pulse least width, ns
`define ACPS_SYNC_MIN_NS 50
`define ACPS_SYNC_MIN_CYC ((`ACPS_SYNC_MIN_NS * `ACPS_CLK_MHZ + 999) / 1000)
// default charge, discharge and dead-time counts
`define ACPS_CHG_CYC_RST 16'h0046
`define ACPS_DIS_CYC_RST 16'h001e
`define ACPS_DEAD_CYC_RST 8'h05
// soft-start width and thresholds: 0.5 V and 1.25 V and 5 V on a 0..5 V scale
`define ACPS_SS_W 12
`define ACPS_SS_FULL 12'hfff
`define ACPS_SS_HALF_V 12'h199
`define ACPS_SS_ZERO_DUTY 12'h400
// slow discharge divides the soft-start step
`define ACPS_SS_SLOW_DIV 8'h08

`endif

// File: acps_pkg.sv
`default_nettype none
package acps_pkg;
  typedef enum logic [1:0] {
    ACPS_RUN = 2'b00,
    ACPS_UV_DRAIN = 2'b01,
    ACPS_OV_HOLD = 2'b10,
    ACPS_OFF = 2'b11
  } acps_state_t;

  typedef enum logic [0:0] {
    ACPS_CHARGE = 1'b0,
    ACPS_RESET = 1'b1
  } acps_osc_t;

  // analog monitor flags, already compared outside
  typedef struct packed {
    logic uv_ok;
    logic ov_trip;
    logic vref_ok;
  } acps_mon_t;

  // gate outputs
  typedef struct packed {
    logic main_on;
    logic clamp_on;
  } acps_gate_t;
endpackage
`default_nettype wire

// File: acps_dead.sv
`timescale 1ns/1ps
`default_nettype none
// turn-on delay for one gate: rising request waits, falling drops the gate on the next edge
module acps_dead #(
  parameter int DW = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [DW-1:0] i_dead,
  output logic o_gate
);
  if (DW < 1) begin : g_width_check
    $error("acps_dead: width too small");
  end

  logic [DW-1:0] cnt_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_gate <= 1'b0;
    end else if (!i_req) begin
      cnt_q <= '0;
      o_gate <= 1'b0;
    end else if (cnt_q >= i_dead) begin
      o_gate <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: acps_seq.sv
// How it works
// - undervoltage shutdown forces main gate off
// - clamp keeps switching during undervoltage soft-start discharge
// - no restart while undervoltage discharge runs
// - overvoltage disables both gates during discharge
// - overvoltage trip starts slow soft-start discharge
// - resume at 0.5 V with overvoltage gone
// - clamp is complement of main normally
// - skipped main pulse also skips clamp
// - sync out pulses at ramp peak
// - main on only in charge interval plus the first reset cycle, since its gate output lags the request by one cycle
// - sync rising edge ends charge interval
// - valley starts charge by itself
// - flat ramp portion holds both outputs off
// - sync held high past the reset interval keeps both gates off
// - tied sync terminals run in phase
// - gates switch only above zero-duty boundary, save the clamp in undervoltage discharge
// - gates switch only with reference rail good, save the clamp in undervoltage discharge
`include "acps_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acps_seq #(
  parameter int CW = 16,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // monitors and loop
  input wire acps_pkg::acps_mon_t i_mon,
  input wire logic i_loop_demand,
  input wire logic [CW-1:0] i_chg_cyc,
  input wire logic [CW-1:0] i_dis_cyc,
  input wire logic [DW-1:0] i_dead_cyc,
  // sync terminal, open drain style
  input wire logic i_sync,
  output logic o_sync,
  output logic o_sync_oe_n,
  input wire logic i_sync_master,
  // gates and status
  output acps_pkg::acps_gate_t o_gate,
  output logic [`ACPS_SS_W-1:0] o_soft_start,
  output acps_pkg::acps_state_t o_state
);
  import acps_pkg::*;

  // elaboration refuses widths the counters cannot serve
  if (CW < 2 || DW < 1) begin : g_width_check
    $error("acps_seq: widths too small");
  end

  acps_state_t state_q;
  acps_osc_t osc_q;
  logic [CW-1:0] ramp_q;
  logic [`ACPS_SS_W-1:0] ss_q;
  logic [7:0] slow_q;
  logic sync_q, sync_rise, peak, valley;
  logic pwm_q, skip_q, main_req, clamp_req, gate_ok;
  logic gate_main, gate_clamp;
  logic [CW-1:0] sync_hold_q;

  function automatic logic ss_at(input logic [`ACPS_SS_W-1:0] v,
                                 input logic [`ACPS_SS_W-1:0] th);
    ss_at = (v <= th);
  endfunction

  assign sync_rise = i_sync && !sync_q;
  assign peak = (osc_q == ACPS_CHARGE) && (ramp_q >= i_chg_cyc - 1'b1);
  assign valley = (osc_q == ACPS_RESET) && (ramp_q >= i_dis_cyc - 1'b1);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) sync_q <= 1'b0;
    else sync_q <= i_sync;
  end

  // cycles the sync input has stayed high in slave mode, saturating
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_sync_master || !i_sync) sync_hold_q <= '0;
    else if (sync_hold_q != '1) sync_hold_q <= sync_hold_q + 1'b1;
  end

  // oscillator: timing capacitor as a counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      osc_q <= ACPS_CHARGE;
      ramp_q <= '0;
    end else if (osc_q == ACPS_CHARGE) begin
      if (peak || (!i_sync_master && sync_rise)) begin
        osc_q <= ACPS_RESET;
        ramp_q <= '0;
      end else begin
        ramp_q <= ramp_q + 1'b1;
      end
    end else if (valley) begin
      // level-sensitive: a held sync keeps the ramp flat at valley
      if (!(i_sync && !i_sync_master)) begin
        osc_q <= ACPS_CHARGE;
        ramp_q <= '0;
      end
    end else begin
      ramp_q <= ramp_q + 1'b1;
    end
  end

  // sync output pulse at ramp peak, one cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) o_sync <= 1'b0;
    else o_sync <= i_sync_master && peak;
  end
  assign o_sync_oe_n = !i_sync_master;

  // shutdown sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ACPS_OFF;
    end else begin
      case (state_q)
        ACPS_RUN: begin
          if (i_mon.ov_trip) state_q <= ACPS_OV_HOLD;
          else if (!i_mon.uv_ok) state_q <= ACPS_UV_DRAIN;
        end
        ACPS_UV_DRAIN: begin
          if (i_mon.ov_trip) state_q <= ACPS_OV_HOLD;
          else if (ss_at(ss_q, `ACPS_SS_HALF_V)) state_q <= ACPS_OFF;
        end
        ACPS_OV_HOLD: begin
          if (ss_at(ss_q, `ACPS_SS_HALF_V) && !i_mon.ov_trip) state_q <= ACPS_OFF;
        end
        ACPS_OFF: begin
          if (i_mon.uv_ok && !i_mon.ov_trip && i_mon.vref_ok &&
              ss_at(ss_q, `ACPS_SS_HALF_V)) state_q <= ACPS_RUN;
        end
        default: state_q <= ACPS_OFF;
      endcase
    end
  end

  // soft-start: one step per ramp peak in run, one step per 8 cycles on shutdown
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ss_q <= '0;
      slow_q <= '0;
    end else if (state_q == ACPS_RUN) begin
      slow_q <= '0;
      if (ss_q != `ACPS_SS_FULL && peak) ss_q <= ss_q + 1'b1;
    end else if (state_q == ACPS_OFF) begin
      slow_q <= '0;
      ss_q <= '0;
    end else begin
      // slow drain gives the clamp time to empty its capacitor
      slow_q <= (slow_q >= `ACPS_SS_SLOW_DIV - 8'h01) ? 8'h00 : slow_q + 8'h01;
      if (slow_q == 8'h00 && ss_q != '0) ss_q <= ss_q - 1'b1;
    end
  end

  assign gate_ok = i_mon.vref_ok && !ss_at(ss_q, `ACPS_SS_ZERO_DUTY);

  // pwm latch: on during charge only, skip cycle on zero demand
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pwm_q <= 1'b0;
      skip_q <= 1'b1;
    end else if (osc_q == ACPS_RESET) begin
      pwm_q <= 1'b0;
      skip_q <= !i_loop_demand;
    end else begin
      pwm_q <= !skip_q && i_loop_demand && !peak;
    end
  end

  // a trip drops both requests before the state register catches up
  assign main_req = (state_q == ACPS_RUN) && gate_ok && pwm_q && !i_mon.ov_trip &&
                    (osc_q == ACPS_CHARGE);
  // clamp fills the reset interval unless skipped or halted
  assign clamp_req = ((state_q == ACPS_RUN && gate_ok) ||
                      state_q == ACPS_UV_DRAIN) &&
                     !skip_q && !pwm_q && !(valley && i_sync) &&
                     !i_mon.ov_trip && (osc_q == ACPS_RESET);

  // turn-on delay per gate so the two never overlap
  acps_dead #(.DW(DW)) u_dead_main (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_req(main_req),
    .i_dead(i_dead_cyc),
    .o_gate(gate_main)
  );
  acps_dead #(.DW(DW)) u_dead_clamp (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_req(clamp_req && !gate_main),
    .i_dead(i_dead_cyc),
    .o_gate(gate_clamp)
  );
  // one driver for the whole gate struct
  assign o_gate = '{main_on: gate_main, clamp_on: gate_clamp};

  assign o_soft_start = ss_q;
  assign o_state = state_q;

  property p_ov_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      state_q == ACPS_OV_HOLD |-> !o_gate.main_on && !o_gate.clamp_on;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on in overvoltage");
  property p_ov_at_once;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_mon.ov_trip |=> !o_gate.main_on && !o_gate.clamp_on;
  endproperty
  a_ov_at_once: assert property (p_ov_at_once) else $error("gate on after trip");
  property p_uv_main;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      state_q == ACPS_UV_DRAIN |=> !o_gate.main_on;
  endproperty
  a_uv_main: assert property (p_uv_main) else $error("main on in uv");
  property p_no_overlap;
    @(posedge i_core_clk) disable iff (!i_rst_n) !(o_gate.main_on && o_gate.clamp_on);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
  sequence s_reset_two;
    osc_q == ACPS_RESET ##1 osc_q == ACPS_RESET;
  endsequence
  property p_reset_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_reset_two |-> !o_gate.main_on;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("main on in reset");
  property p_sync_peak;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_sync_master && peak |=> o_sync;
  endproperty
  a_sync_peak: assert property (p_sync_peak) else $error("no sync at peak");
  // short legal sync pulses let the clamp run; only a hold past the reset interval blanks it
  property p_sync_high;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      sync_hold_q > i_dis_cyc |-> !o_gate.main_on && !o_gate.clamp_on;
  endproperty
  a_sync_high: assert property (p_sync_high) else $error("gate on with sync high");
  property p_ov_enter;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      state_q == ACPS_RUN && i_mon.ov_trip |=> state_q == ACPS_OV_HOLD;
  endproperty
  a_ov_enter: assert property (p_ov_enter) else $error("ov not taken");
  property p_uv_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      state_q == ACPS_UV_DRAIN |=> state_q != ACPS_RUN;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("restart during drain");
endmodule
`default_nettype wire

// File: acps_fet_model.sv
`timescale 1ns/1ps
`default_nettype none
module acps_fet_model (
  // clock and clear
  input wire logic i_core_clk,
  input wire logic i_clr,
  // gate pins and dead time
  input wire acps_pkg::acps_gate_t i_gate,
  input wire logic [7:0] i_dead,
  // observations
  output logic [15:0] o_main_cnt,
  output logic [15:0] o_clamp_cnt,
  output logic [15:0] o_max_on,
  output logic o_bad
);
  import acps_pkg::*;
  acps_gate_t prev_q;
  logic [15:0] run_q;
  logic [15:0] gap_q;
  logic m_rise;
  logic c_rise;
  assign m_rise = i_gate.main_on & ~prev_q.main_on;
  assign c_rise = i_gate.clamp_on & ~prev_q.clamp_on;
  always_ff @(posedge i_core_clk) begin
    prev_q <= i_gate;
    if (i_clr) begin
      o_main_cnt <= 16'h0;
      o_clamp_cnt <= 16'h0;
      o_max_on <= 16'h0;
      o_bad <= 1'b0;
      run_q <= 16'h0;
      gap_q <= 16'hffff;
    end else begin
      if (m_rise) o_main_cnt <= o_main_cnt + 16'h1;
      if (c_rise) o_clamp_cnt <= o_clamp_cnt + 16'h1;
      run_q <= i_gate.main_on ? run_q + 16'h1 : 16'h0;
      if (i_gate.main_on && run_q >= o_max_on) o_max_on <= run_q + 16'h1;
      // saturate so a long idle never wraps into a false short gap
      gap_q <= (i_gate.main_on | i_gate.clamp_on) ? 16'h0 : gap_q + 16'(gap_q != 16'hffff);
      // both switches on shorts the clamp capacitor
      if ((m_rise | c_rise) && gap_q < 16'(i_dead)) o_bad <= 1'b1;
      if (i_gate.main_on & i_gate.clamp_on) o_bad <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: acps_seq_test.sv
`include "acps_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acps_seq_test;
  import acps_pkg::*;
  logic clk, rst_n, demand, sync_tb, master, clr, watch, o_sync, oe_n, sync_pin, bad;
  acps_mon_t mon;
  logic [7:0] dead;
  acps_gate_t gate;
  logic [11:0] ss, ss_q, ss_t;
  acps_state_t st, st_q;
  logic [15:0] mcnt, ccnt, max_on, scnt;
  int mismatches, num_checks, cycles;
  acps_state_t exp_q[$];
  assign sync_pin = !oe_n ? o_sync : sync_tb;
  acps_seq dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_mon(mon), .i_loop_demand(demand),
    .i_chg_cyc(16'h000c), .i_dis_cyc(16'h0009), .i_dead_cyc(dead), .i_sync(sync_pin),
    .o_sync(o_sync), .o_sync_oe_n(oe_n), .i_sync_master(master), .o_gate(gate),
    .o_soft_start(ss), .o_state(st));
  acps_fet_model fet (.i_core_clk(clk), .i_clr(clr), .i_gate(gate), .i_dead(dead),
    .o_main_cnt(mcnt), .o_clamp_cnt(ccnt), .o_max_on(max_on), .o_bad(bad));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clear;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask
  // state changes are matched against the driver's notes, oldest first
  always @(posedge clk) begin
    if (rst_n && watch && st !== st_q) begin
      if (exp_q.size() == 0) chk("state extra", 16'(st_q), 16'(st));
      else chk("state", 16'(exp_q.pop_front()), 16'(st));
      if (st === ACPS_OFF) chk("ss at restart", 16'h1, 16'(ss_q <= `ACPS_SS_HALF_V));
    end
    st_q <= st;
    ss_q <= ss;
    if (clr) scnt <= 16'h0;
    else if (o_sync === 1'b1) scnt <= scnt + 16'h1;
    cycles++;
    if (cycles > 100000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hb58aad50));
    mon = '{uv_ok: 1'b1, ov_trip: 1'b0, vref_ok: 1'b1};
    {rst_n, demand, sync_tb, master, clr, watch} = 6'b010111;
    dead = 8'(1 + $urandom % 4);
    exp_q.push_back(ACPS_RUN);
    cyc(20);
    rst_n = 1'b1;
    for (int i = 0; i < 40000 && ss < 12'h580; i++) cyc(1);
    clear();
    cyc(210);
    chk("main pulses", 16'd10, mcnt);
    chk("clamp pulses", 16'd10, ccnt);
    chk("sync pulses", 16'd10, scnt);
    chk("sync driven", 16'h0, 16'(oe_n));
    chk("main on max", 16'h1, 16'(max_on <= 16'd12));
    chk("overlap", 16'h0, 16'(bad));
    // soft start is past zero duty here, so only the reference gate can stop pulses
    mon.vref_ok = 1'b0;
    cyc(30);
    clear();
    cyc(200);
    chk("vref gates", 16'h0, mcnt | ccnt);
    mon.vref_ok = 1'b1;
    demand = 1'b0;
    cyc(30);
    clear();
    cyc(210);
    chk("skip main", 16'h0, mcnt);
    chk("skip clamp", 16'h0, ccnt);
    demand = 1'b1;
    master = 1'b0;
    cyc(30);
    clear();
    // 5 cycles high clears the least width yet stays under the off share
    repeat (10) begin
      sync_tb = 1'b1;
      cyc(5);
      sync_tb = 1'b0;
      cyc(10);
    end
    chk("sync main", 16'h1, 16'(mcnt >= 16'd9));
    chk("sync on max", 16'h1, 16'(max_on <= 16'd8));
    sync_tb = 1'b1;
    cyc(30);
    clear();
    cyc(200);
    chk("held main", 16'h0, mcnt);
    chk("held clamp", 16'h0, ccnt);
    sync_tb = 1'b0;
    master = 1'b1;
    cyc(60);
    ss_t = ss;
    exp_q.push_back(ACPS_OV_HOLD);
    exp_q.push_back(ACPS_OFF);
    exp_q.push_back(ACPS_RUN);
    mon.ov_trip = 1'b1;
    cyc(3);
    clear();
    cyc(200);
    chk("ov gates", 16'h0, mcnt | ccnt);
    chk("ov discharge", 16'h1, 16'(ss < ss_t));
    for (int i = 0; i < 20000 && ss > `ACPS_SS_HALF_V; i++) cyc(1);
    cyc(100);
    chk("ov held", 16'(ACPS_OV_HOLD), 16'(st));
    mon.ov_trip = 1'b0;
    for (int i = 0; i < 40000 && ss < 12'h480; i++) cyc(1);
    exp_q.push_back(ACPS_UV_DRAIN);
    exp_q.push_back(ACPS_OFF);
    exp_q.push_back(ACPS_RUN);
    mon.uv_ok = 1'b0;
    cyc(3);
    clear();
    cyc(100);
    mon.uv_ok = 1'b1;
    cyc(100);
    chk("uv main", 16'h0, mcnt);
    chk("uv clamp", 16'h1, 16'(ccnt > 16'h0));
    chk("uv no restart", 16'(ACPS_UV_DRAIN), 16'(st));
    for (int i = 0; i < 20000 && st !== ACPS_RUN; i++) cyc(1);
    // the watcher sees the last change one edge late
    cyc(2);
    watch = 1'b0;
    chk("notes left", 16'h0, 16'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
